// ===== cmc_top.sv
// charger mode control: registers, mode decode, charge phases, port control
// ---------------------------------------------------------------
// Notes on behaviour
// R1 - enable pin low forces shutdown, every function off
// R2 - no equipment or standby bit set: activity flag low, standby
// R3 - active with clock disable set: digital clock stopped, core frozen; here the charge phase returns to idle instead
// R4 - active, clock running, converter enable low: converter off only
// R5 - active, clock running, converter enable high: normal mode runs converter
// R6 - direction bit one selects discharging; host keeps it zero for charging
// R7 - internal feedback takes 12-bit split setpoint, 2.15 mV steps, 5 V default
// R8 - new setpoint applies only after load strobe written as one
// R9 - forced continuous bit honoured only while forced discontinuous is zero
// R10 - forced discontinuous bit resets high
// R11 - auto termination on: end of charge once voltage and current met
// R12 - auto termination off: keep charging at setpoint, host ends it
// R13 - after end of charge, recharge threshold crossing returns to constant current
// R14 - host enables bus constant current loop when bus limiting needed
// R15 - host writes gain pattern 11 for charging, gain 200
// R16 - monitor output only with enable bit; four-bit selector picks signal
// R17 - discharging with port current under about 50 mA flags small current
// R18 - adapter attach and detach shown in port ready status bits
// R19 - each gate driver follows its own port switch bit only
// R20 - host programs charge settings with direction zero before converter enable
// R21 - port roles follow the two-bit port role field
// R22 - host starts in forced discontinuous, ramps limit, then clears it; charge_setup writes each limit once and leaves it set
// R23 - mode decode is continuous, no commit step needed
// ---------------------------------------------------------------
`timescale 1ns/1ps
module cmc_top
  import cmc_pkg::*;
#(
  parameter int SET_W = CMC_SET_W
) (
  input wire logic core_clk,
  input wire logic srst,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // asynchronous pins and analog comparators
  input wire logic enable_pin,
  input wire logic equipment_attached,
  input wire logic [1:0] port_attach_detect,
  input wire logic vbat_at_target,
  input wire logic term_voltage_ok,
  input wire logic term_current_ok,
  input wire logic vbat_below_recharge,
  input wire logic port_current_small,
  // controls to the analog side
  output cmc_mode_t operating_mode,
  output logic activity_flag,
  output logic digital_clk_enable,
  output logic converter_enable,
  output logic discharge_direction,
  output logic forced_discontinuous,
  output logic ccm_select,
  output cmc_phase_t charge_phase,
  output logic internal_feedback,
  output logic [SET_W-1:0] bus_output_setpoint,
  output logic bus_cc_loop_enable,
  output logic analog_monitor_enable,
  output logic [3:0] analog_monitor_select,
  output logic first_port_gate,
  output logic second_port_gate,
  output logic [1:0] port_role_field,
  output logic small_current_flag
);
  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  cmc_pin_if #(.W(CMC_PIN_W)) pin_bus ();

  assign pin_bus.raw = {port_current_small, vbat_below_recharge, term_current_ok,
                        term_voltage_ok, vbat_at_target, port_attach_detect[1],
                        port_attach_detect[0], equipment_attached, enable_pin};

  cmc_pin_sync #(.W(CMC_PIN_W)) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .pins(pin_bus)
  );

  logic en_s;
  logic attach_s;
  assign en_s = pin_bus.clean[CMC_PIN_EN];
  assign attach_s = pin_bus.clean[CMC_PIN_ATTACH];

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [7:0] conv_mode_q;
  logic [7:0] chg_one_q;
  logic [7:0] chg_two_q;
  logic [CMC_SET_HIGH_W-1:0] set_high_q;
  logic [7:0] set_low_q;
  logic [7:0] chg_cur_q;
  logic [7:0] in_reg_q;
  logic [7:0] port_sw_q;
  logic [7:0] sense_gain_q;
  logic [7:0] clk_gate_q;
  logic [7:0] port_role_q;
  logic [7:0] loop_mon_q;
  logic [7:0] full_stby_q;
  logic wipe;

  // losing the enable pin wipes all settings, as a cold start would
  assign wipe = srst || !en_s; // [R1]

  always_ff @(posedge core_clk) begin
    if (wipe) begin
      conv_mode_q <= CMC_RST_CONV_MODE; // [R10]
      chg_one_q <= CMC_RST_ZERO;
      chg_two_q <= CMC_RST_ZERO;
      set_high_q <= CMC_RST_SETPOINT[SET_W-1:8];
      set_low_q <= CMC_RST_SETPOINT[7:0];
      chg_cur_q <= CMC_RST_ZERO;
      in_reg_q <= CMC_RST_ZERO;
      port_sw_q <= CMC_RST_ZERO;
      sense_gain_q <= CMC_RST_ZERO;
      clk_gate_q <= CMC_RST_ZERO;
      port_role_q <= CMC_RST_ZERO;
      loop_mon_q <= CMC_RST_ZERO;
      full_stby_q <= CMC_RST_ZERO;
    end else begin
      // load strobe never stays stored, it reads back as zero
      chg_two_q[CMC_BIT_LOAD] <= 1'b0;
      if (reg_wr) begin
        case (reg_addr)
          CMC_OFF_CONV_MODE: begin
            conv_mode_q <= reg_wdata;
          end
          CMC_OFF_CHG_ONE: begin
            chg_one_q <= reg_wdata;
          end
          CMC_OFF_CHG_TWO: begin
            chg_two_q <= reg_wdata;
          end
          CMC_OFF_SET_HIGH: begin
            set_high_q <= reg_wdata[CMC_SET_HIGH_W-1:0];
          end
          CMC_OFF_SET_LOW: begin
            set_low_q <= reg_wdata;
          end
          CMC_OFF_CHG_CUR: begin
            chg_cur_q <= reg_wdata;
          end
          CMC_OFF_IN_REG: begin
            in_reg_q <= reg_wdata;
          end
          CMC_OFF_PORT_SW: begin
            port_sw_q <= reg_wdata;
          end
          CMC_OFF_SENSE_GAIN: begin
            sense_gain_q <= reg_wdata;
          end
          CMC_OFF_CLK_GATE: begin
            clk_gate_q <= reg_wdata;
          end
          CMC_OFF_PORT_ROLE: begin
            port_role_q <= reg_wdata;
          end
          CMC_OFF_LOOP_MON: begin
            loop_mon_q <= reg_wdata;
          end
          CMC_OFF_FULL_STBY: begin
            full_stby_q <= reg_wdata;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // operating mode decode
  // ---------------------------------------------------------------
  cmc_mode_t mode_d;
  cmc_mode_t mode_q;

  always_comb begin
    if (!en_s) begin
      mode_d = CMC_MODE_SHUTDOWN; // [R1]
    end else if (!attach_s || full_stby_q[CMC_BIT_STBY]) begin
      mode_d = CMC_MODE_STANDBY; // [R2]
    end else if (clk_gate_q[CMC_BIT_CLK_DIS]) begin
      mode_d = CMC_MODE_CLK_GATED; // [R3]
    end else if (!conv_mode_q[CMC_BIT_CONV_EN]) begin
      mode_d = CMC_MODE_CONV_OFF; // [R4]
    end else begin
      mode_d = CMC_MODE_NORMAL; // [R5]
    end
  end

  // re-evaluated every cycle from live bits [R23]
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_q <= CMC_MODE_SHUTDOWN;
    end else begin
      mode_q <= mode_d;
    end
  end

  logic active;
  logic core_run;
  logic normal;
  logic discharging;
  assign active = (mode_q != CMC_MODE_SHUTDOWN) && (mode_q != CMC_MODE_STANDBY);
  // register port stays alive while gated so the host can restart the clock
  assign core_run = (mode_q == CMC_MODE_CONV_OFF) || (mode_q == CMC_MODE_NORMAL); // [R3]
  assign normal = (mode_q == CMC_MODE_NORMAL);
  assign discharging = chg_two_q[CMC_BIT_DIR]; // [R6]

  // ---------------------------------------------------------------
  // charge phase sequencing
  // ---------------------------------------------------------------
  cmc_phase_t phase_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      phase_q <= CMC_PH_IDLE;
    end else if (!normal || discharging) begin
      phase_q <= CMC_PH_IDLE;
    end else if (core_run) begin
      case (phase_q)
        CMC_PH_IDLE: begin
          phase_q <= CMC_PH_CC;
        end
        CMC_PH_CC: begin
          if (pin_bus.clean[CMC_PIN_AT_TGT]) begin
            phase_q <= CMC_PH_CV;
          end
        end
        CMC_PH_CV: begin
          // without auto termination it simply holds the setpoint [R12]
          if (chg_two_q[CMC_BIT_AUTO_TERM] && pin_bus.clean[CMC_PIN_TERM_V]
              && pin_bus.clean[CMC_PIN_TERM_I]) begin
            phase_q <= CMC_PH_EOC; // [R11]
          end
        end
        CMC_PH_EOC: begin
          if (pin_bus.clean[CMC_PIN_RECHG]) begin
            phase_q <= CMC_PH_CC; // [R13]
          end
        end
        default: begin
          phase_q <= CMC_PH_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // output setpoint with load strobe
  // ---------------------------------------------------------------
  logic [SET_W-1:0] active_set_q;

  always_ff @(posedge core_clk) begin
    if (wipe) begin
      active_set_q <= CMC_RST_SETPOINT; // [R7]
    end else if (reg_wr && (reg_addr == CMC_OFF_CHG_TWO) && reg_wdata[CMC_BIT_LOAD]) begin
      // staged halves only reach the loop on the strobe [R8]
      active_set_q <= {set_high_q, set_low_q}; // [R7]
    end
  end

  // ---------------------------------------------------------------
  // converter and port outputs
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      operating_mode <= CMC_MODE_SHUTDOWN;
      activity_flag <= 1'b0;
      digital_clk_enable <= 1'b0;
      converter_enable <= 1'b0;
      discharge_direction <= 1'b0;
      forced_discontinuous <= 1'b1;
      ccm_select <= 1'b0;
      charge_phase <= CMC_PH_IDLE;
      internal_feedback <= 1'b0;
      bus_output_setpoint <= CMC_RST_SETPOINT;
      bus_cc_loop_enable <= 1'b0;
      analog_monitor_enable <= 1'b0;
      analog_monitor_select <= 4'h0;
      first_port_gate <= 1'b0;
      second_port_gate <= 1'b0;
      port_role_field <= 2'b00;
    end else begin
      operating_mode <= mode_q;
      activity_flag <= active; // [R2]
      digital_clk_enable <= core_run; // [R3]
      // end of charge turns the converter off until recharge [R11]
      converter_enable <= normal && (phase_q != CMC_PH_EOC); // [R5]
      discharge_direction <= discharging; // [R6]
      forced_discontinuous <= conv_mode_q[CMC_BIT_FORCED_DISCONTINUOUS];
      // forced discontinuous dominates forced continuous [R9]
      ccm_select <= conv_mode_q[CMC_BIT_CCM] && !conv_mode_q[CMC_BIT_FORCED_DISCONTINUOUS]; // [R9]
      charge_phase <= phase_q;
      internal_feedback <= !chg_two_q[CMC_BIT_FEEDBACK_SELECT]; // [R7]
      bus_output_setpoint <= active_set_q; // [R8]
      bus_cc_loop_enable <= active && loop_mon_q[CMC_BIT_BUS_CC];
      analog_monitor_enable <= active && port_sw_q[CMC_BIT_MON_EN]; // [R16]
      analog_monitor_select <= loop_mon_q[3:0]; // [R16]
      // each gate bit drives its own port and nothing else
      first_port_gate <= active && port_sw_q[CMC_BIT_GATE0]; // [R19]
      second_port_gate <= active && port_sw_q[CMC_BIT_GATE1]; // [R19]
      port_role_field <= port_role_q[1:0];
    end
  end

  // ---------------------------------------------------------------
  // small current indication
  // ---------------------------------------------------------------
  logic small_set;
  logic small_clr;
  assign small_set = normal && discharging && pin_bus.clean[CMC_PIN_SMALL_I]; // [R17]
  assign small_clr = reg_rd && (reg_addr == CMC_OFF_PORT_STAT);

  always_ff @(posedge core_clk) begin
    if (wipe) begin
      small_current_flag <= 1'b0;
    end else if (small_set) begin
      // a new event in the read cycle is kept
      small_current_flag <= 1'b1; // [R17]
    end else if (small_clr) begin
      small_current_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register read path
  // ---------------------------------------------------------------
  logic [7:0] status_word;
  assign status_word = {1'b0, mode_q, 1'b0, small_current_flag,
                        pin_bus.clean[CMC_PIN_RDY1], pin_bus.clean[CMC_PIN_RDY0]}; // [R18]

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          CMC_OFF_CONV_MODE: reg_rdata <= conv_mode_q;
          CMC_OFF_CHG_ONE: reg_rdata <= chg_one_q;
          CMC_OFF_CHG_TWO: reg_rdata <= chg_two_q;
          CMC_OFF_SET_HIGH: reg_rdata <= {4'h0, set_high_q};
          CMC_OFF_SET_LOW: reg_rdata <= set_low_q;
          CMC_OFF_CHG_CUR: reg_rdata <= chg_cur_q;
          CMC_OFF_IN_REG: reg_rdata <= in_reg_q;
          CMC_OFF_PORT_SW: reg_rdata <= port_sw_q;
          CMC_OFF_SENSE_GAIN: reg_rdata <= sense_gain_q;
          CMC_OFF_CLK_GATE: reg_rdata <= clk_gate_q;
          CMC_OFF_PORT_ROLE: reg_rdata <= port_role_q;
          CMC_OFF_LOOP_MON: reg_rdata <= loop_mon_q;
          CMC_OFF_FULL_STBY: reg_rdata <= full_stby_q;
          CMC_OFF_PORT_STAT: reg_rdata <= status_word;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

// ===== cmc_pkg.sv
// constants and types for the charger mode control block
package cmc_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CMC_OFF_CONV_MODE = 8'h00;
  localparam logic [7:0] CMC_OFF_CHG_ONE = 8'h04;
  localparam logic [7:0] CMC_OFF_CHG_TWO = 8'h05;
  localparam logic [7:0] CMC_OFF_SET_HIGH = 8'h06;
  localparam logic [7:0] CMC_OFF_SET_LOW = 8'h07;
  localparam logic [7:0] CMC_OFF_CHG_CUR = 8'h08;
  localparam logic [7:0] CMC_OFF_IN_REG = 8'h1b;
  localparam logic [7:0] CMC_OFF_PORT_SW = 8'h1c;
  localparam logic [7:0] CMC_OFF_SENSE_GAIN = 8'h20;
  localparam logic [7:0] CMC_OFF_CLK_GATE = 8'h27;
  localparam logic [7:0] CMC_OFF_PORT_ROLE = 8'h28;
  localparam logic [7:0] CMC_OFF_LOOP_MON = 8'h2d;
  localparam logic [7:0] CMC_OFF_FULL_STBY = 8'h2e;
  localparam logic [7:0] CMC_OFF_PORT_STAT = 8'h36;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CMC_BIT_CONV_EN = 0;
  localparam int CMC_BIT_FORCED_DISCONTINUOUS = 2;
  localparam int CMC_BIT_CCM = 3;
  localparam int CMC_BIT_DIR = 0;
  localparam int CMC_BIT_AUTO_TERM = 1;
  localparam int CMC_BIT_FEEDBACK_SELECT = 2;
  localparam int CMC_BIT_LOAD = 3;
  localparam int CMC_BIT_GATE0 = 0;
  localparam int CMC_BIT_GATE1 = 1;
  localparam int CMC_BIT_MON_EN = 2;
  localparam int CMC_BIT_CLK_DIS = 0;
  localparam int CMC_BIT_BUS_CC = 4;
  localparam int CMC_BIT_STBY = 7;
  localparam int CMC_BIT_SMALL_I = 2;
  localparam int CMC_SET_HIGH_W = 4;
  localparam int CMC_SET_W = 12;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CMC_RST_CONV_MODE = 8'h04;
  localparam logic [7:0] CMC_RST_ZERO = 8'h00;
  // 5 V at 2.15 mV per step rounds to code 2326
  localparam logic [11:0] CMC_RST_SETPOINT = 12'h0916;
  // ---------------------------------------------------------------
  // modes and charge phases
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CMC_MODE_SHUTDOWN = 3'b000,
    CMC_MODE_STANDBY = 3'b001,
    CMC_MODE_CLK_GATED = 3'b011,
    CMC_MODE_CONV_OFF = 3'b010,
    CMC_MODE_NORMAL = 3'b110
  } cmc_mode_t;
  typedef enum logic [1:0] {
    CMC_PH_IDLE = 2'b00,
    CMC_PH_CC = 2'b01,
    CMC_PH_CV = 2'b11,
    CMC_PH_EOC = 2'b10
  } cmc_phase_t;
  // pin vector layout into the synchroniser
  localparam int CMC_PIN_EN = 0;
  localparam int CMC_PIN_ATTACH = 1;
  localparam int CMC_PIN_RDY0 = 2;
  localparam int CMC_PIN_RDY1 = 3;
  localparam int CMC_PIN_AT_TGT = 4;
  localparam int CMC_PIN_TERM_V = 5;
  localparam int CMC_PIN_TERM_I = 6;
  localparam int CMC_PIN_RECHG = 7;
  localparam int CMC_PIN_SMALL_I = 8;
  localparam int CMC_PIN_W = 9;
endpackage

// ===== cmc_pin_if.sv
// carrier between the pin synchroniser and the control core
`timescale 1ns/1ps
interface cmc_pin_if #(
  parameter int W = 1
);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// ===== cmc_pin_sync.sv
// three-flop synchroniser with agreement filter for asynchronous pins
`timescale 1ns/1ps
module cmc_pin_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic srst,
  cmc_pin_if.sync pins
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] clean_q;

  // ---------------------------------------------------------------
  // per bit chain
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge core_clk) begin
        if (srst) begin
          s1_q[i] <= 1'b0;
          s2_q[i] <= 1'b0;
          s3_q[i] <= 1'b0;
          clean_q[i] <= 1'b0;
        end else begin
          s1_q[i] <= pins.raw[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          // only take a level once two stages agree, so a glitch seen for one cycle never counts
          if (s2_q[i] == s3_q[i]) begin
            clean_q[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate

  assign pins.clean = clean_q;
endmodule

// ===== cmc_top_assertions.sv
// concurrent checks on the charger mode control ports
`timescale 1ns/1ps
module cmc_top_assertions
  import cmc_pkg::*;
#(
  parameter int SET_W = CMC_SET_W
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rvalid,
  input wire logic enable_pin,
  input cmc_mode_t operating_mode,
  input wire logic activity_flag,
  input wire logic digital_clk_enable,
  input wire logic converter_enable,
  input wire logic forced_discontinuous,
  input wire logic ccm_select,
  input wire logic [SET_W-1:0] bus_output_setpoint,
  input wire logic first_port_gate,
  input wire logic second_port_gate,
  input wire logic analog_monitor_enable
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  logic load_hit;
  assign load_hit = reg_wr && reg_addr == CMC_OFF_CHG_TWO && reg_wdata[CMC_BIT_LOAD];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // long enough to cover pin synchroniser plus two output stages
  sequence s_enable_low;
    !enable_pin [*8];
  endsequence
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_shutdown_entry: assert property (s_enable_low |=>
    operating_mode == CMC_MODE_SHUTDOWN && !converter_enable && !activity_flag)
    else $error("enable low did not reach shutdown");
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read without answer");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read");
  a_dcm_priority: assert property (forced_discontinuous |-> !ccm_select)
    else $error("continuous mode despite forced discontinuous");
  a_active_decode: assert property (activity_flag ==
    (operating_mode inside {CMC_MODE_CLK_GATED, CMC_MODE_CONV_OFF, CMC_MODE_NORMAL}))
    else $error("activity flag disagrees with mode");
  a_clock_gate: assert property (digital_clk_enable ==
    (operating_mode inside {CMC_MODE_CONV_OFF, CMC_MODE_NORMAL}))
    else $error("clock enable disagrees with mode");
  a_conv_normal: assert property (converter_enable |-> operating_mode == CMC_MODE_NORMAL)
    else $error("converter on outside normal mode");
  a_gate_active: assert property ((first_port_gate || second_port_gate ||
    analog_monitor_enable) |-> activity_flag)
    else $error("port driver on while inactive");
  a_setpoint_load: assert property ($changed(bus_output_setpoint) |->
    $past(load_hit, 2) || bus_output_setpoint == CMC_RST_SETPOINT)
    else $error("setpoint moved without load strobe");
endmodule
bind cmc_top cmc_top_assertions #(.SET_W(SET_W)) u_chk (.core_clk(core_clk), .srst(srst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rvalid(reg_rvalid), .enable_pin(enable_pin), .operating_mode(operating_mode),
  .activity_flag(activity_flag), .digital_clk_enable(digital_clk_enable),
  .converter_enable(converter_enable), .forced_discontinuous(forced_discontinuous),
  .ccm_select(ccm_select), .bus_output_setpoint(bus_output_setpoint),
  .first_port_gate(first_port_gate), .second_port_gate(second_port_gate),
  .analog_monitor_enable(analog_monitor_enable));

// ===== cmc_host_model.sv
// host microcontroller model on the register port
`timescale 1ns/1ps
module cmc_host_model
  import cmc_pkg::*;
(
  input wire logic core_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // one strobe cycle, then an idle cycle so strobes never merge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [8:0] q);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    q = {reg_rvalid, reg_rdata};
    reg_rd = 1'b0;
  endtask
  // settings first, direction clear, converter enable last
  task automatic charge_setup();
    wr(CMC_OFF_CHG_ONE, 8'h03);
    wr(CMC_OFF_IN_REG, 8'h01);
    wr(CMC_OFF_SENSE_GAIN, 8'hc0);
    wr(CMC_OFF_LOOP_MON, 8'h10);
    wr(CMC_OFF_CHG_CUR, 8'h10);
    wr(CMC_OFF_PORT_ROLE, 8'h03);
    wr(CMC_OFF_CHG_TWO, 8'h00);
    wr(CMC_OFF_CONV_MODE, 8'h05);
  endtask
endmodule

// ===== tb.sv
// self-checking bench for the charger mode control block
`timescale 1ns/1ps
module tb
  import cmc_pkg::*;
;
  logic core_clk = 0, srst = 1, enable_pin = 1, equipment_attached = 0;
  logic reg_wr, reg_rd, reg_rvalid, vbat_at_target = 0, term_voltage_ok = 0;
  logic term_current_ok = 0, vbat_below_recharge = 0, port_current_small = 0;
  logic [1:0] port_attach_detect = 2'b00, port_role_field;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  cmc_mode_t operating_mode;
  cmc_phase_t charge_phase;
  logic activity_flag, digital_clk_enable, converter_enable, discharge_direction;
  logic forced_discontinuous, ccm_select, internal_feedback, bus_cc_loop_enable;
  logic analog_monitor_enable, first_port_gate, second_port_gate, small_current_flag;
  logic [11:0] bus_output_setpoint;
  logic [3:0] analog_monitor_select;
  logic [8:0] q;
  int n_mismatch = 0, checked = 0;
  cmc_top DUT (.*);
  cmc_host_model host (.*);
  always #10 core_clk = ~core_clk;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_defaults();
    chk(forced_discontinuous, 1);
    chk(bus_output_setpoint, CMC_RST_SETPOINT);
    chk(internal_feedback, 1);
    chk({activity_flag, operating_mode}, CMC_MODE_STANDBY);
    host.rd(CMC_OFF_CONV_MODE, q);
    chk(q, {1'b1, CMC_RST_CONV_MODE});
    host.rd(8'h50, q);
    chk(q, 9'h100);
  endtask
  task automatic t_modes();
    logic [7:0] ta[6] = '{8'h27, 8'h27, 8'h00, 8'h00, 8'h2e, 8'h2e};
    logic [7:0] td[6] = '{8'h01, 8'h00, 8'h04, 8'h05, 8'h80, 8'h00};
    cmc_mode_t tm[6] = '{CMC_MODE_CLK_GATED, CMC_MODE_NORMAL, CMC_MODE_CONV_OFF,
      CMC_MODE_NORMAL, CMC_MODE_STANDBY, CMC_MODE_NORMAL};
    equipment_attached = 1;
    cyc(8);
    host.charge_setup();
    cyc(4);
    chk({operating_mode, converter_enable}, {CMC_MODE_NORMAL, 1'b1});
    chk({bus_cc_loop_enable, port_role_field}, 3'b111);
    for (int i = 0; i < 6; i++) begin
      host.wr(ta[i], td[i]);
      cyc(4);
      chk(operating_mode, tm[i]);
      chk(activity_flag, tm[i] != CMC_MODE_STANDBY);
      chk(digital_clk_enable, tm[i] inside {CMC_MODE_CONV_OFF, CMC_MODE_NORMAL});
    end
  endtask
  task automatic t_ccm();
    host.wr(CMC_OFF_CONV_MODE, 8'h0d);
    cyc(4);
    chk({forced_discontinuous, ccm_select}, 2'b10);
    host.wr(CMC_OFF_CONV_MODE, 8'h09);
    cyc(4);
    chk({forced_discontinuous, ccm_select}, 2'b01);
    host.wr(CMC_OFF_CONV_MODE, 8'h05);
  endtask
  task automatic t_phase();
    cyc(4);
    chk(charge_phase, CMC_PH_CC);
    vbat_at_target = 1;
    cyc(8);
    chk(charge_phase, CMC_PH_CV);
    term_voltage_ok = 1;
    term_current_ok = 1;
    cyc(8);
    chk({charge_phase, converter_enable}, {CMC_PH_CV, 1'b1});
    host.wr(CMC_OFF_CHG_TWO, 8'h02);
    cyc(4);
    chk({charge_phase, converter_enable}, {CMC_PH_EOC, 1'b0});
    {vbat_at_target, term_voltage_ok, term_current_ok} = 3'b000;
    vbat_below_recharge = 1;
    cyc(8);
    chk({charge_phase, converter_enable}, {CMC_PH_CC, 1'b1});
    vbat_below_recharge = 0;
    host.wr(CMC_OFF_CHG_TWO, 8'h00);
  endtask
  task automatic t_setpoint();
    host.wr(CMC_OFF_SET_HIGH, 8'hf3);
    host.wr(CMC_OFF_SET_LOW, 8'hab);
    cyc(4);
    chk(bus_output_setpoint, CMC_RST_SETPOINT);
    host.rd(CMC_OFF_SET_HIGH, q);
    chk(q, 9'h103);
    host.wr(CMC_OFF_CHG_TWO, 8'h0c);
    cyc(3);
    chk({bus_output_setpoint, internal_feedback}, {12'h3ab, 1'b0});
    host.rd(CMC_OFF_CHG_TWO, q);
    chk(q, 9'h104);
    host.wr(CMC_OFF_CHG_TWO, 8'h00);
  endtask
  task automatic t_ports();
    host.wr(CMC_OFF_PORT_SW, 8'h01);
    cyc(4);
    chk({first_port_gate, second_port_gate, analog_monitor_enable}, 3'b100);
    host.wr(CMC_OFF_PORT_SW, 8'h06);
    host.wr(CMC_OFF_LOOP_MON, 8'h15);
    cyc(4);
    chk({first_port_gate, second_port_gate, analog_monitor_enable}, 3'b011);
    chk(analog_monitor_select, 4'h5);
    port_attach_detect = 2'b10;
    host.wr(CMC_OFF_PORT_STAT, 8'hff);
    cyc(8);
    host.rd(CMC_OFF_PORT_STAT, q);
    chk(q, {2'b10, CMC_MODE_NORMAL, 4'b0010});
  endtask
  task automatic t_small();
    host.wr(CMC_OFF_CHG_TWO, 8'h01);
    port_current_small = 1;
    cyc(8);
    chk({discharge_direction, charge_phase}, {1'b1, CMC_PH_IDLE});
    chk(small_current_flag, 1);
    port_current_small = 0;
    cyc(8);
    host.rd(CMC_OFF_PORT_STAT, q);
    chk(q[2], 1);
    cyc(2);
    chk(small_current_flag, 0);
  endtask
  task automatic t_shutdown();
    host.wr(CMC_OFF_CONV_MODE, 8'h01);
    cyc(4);
    chk(forced_discontinuous, 0);
    enable_pin = 0;
    cyc(10);
    chk({operating_mode, converter_enable, second_port_gate, analog_monitor_enable}, 0);
    enable_pin = 1;
    cyc(8);
    host.rd(CMC_OFF_PORT_SW, q);
    chk(q, 9'h100);
    chk(forced_discontinuous, 1);
  endtask
  initial begin
    cyc(8);
    srst = 0;
    cyc(6);
    t_defaults();
    t_modes();
    t_ccm();
    t_phase();
    t_setpoint();
    t_ports();
    t_small();
    t_shutdown();
    summarize();
  end
  // whole run is a few hundred cycles; this leaves wide margin
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
endmodule
